//--- design/dspao_top.sv
// adder, accumulator, summation, output select and output registers
// assumes products arrive already aligned with the delayed controls
// Overview of operation
// (RQ1) accumulator adds on direction 1, subtracts on 0, or fixed add/sub
// (RQ2) load-select sums the product with zero instead of feedback
// (RQ3) load-select clear works apart from the output register clear
// (RQ4) load-select with preload gives product plus preload, one cycle later
// (RQ5) preload fills only bits 51..16; low bits come through the product
// (RQ6) overflow goes high on the edge after over- or underflow
// (RQ7) overflow lasts one cycle even while the condition stays
// (RQ8) each accumulator has its own round and saturate enables
// (RQ9) accumulator round/saturate only in 18-bit signed q1.15 MAC
// (RQ10) saturated flag reads 1 whenever saturation was applied
// (RQ11) top and bottom adders add on direction 1, subtract on 0
// (RQ12) subtraction gives first minus second, third minus fourth
// (RQ13) adders use the multiplier signedness, delayed 0, 1 or 2
// (RQ14) separate round-only enables after top and bottom adders
// (RQ15) adder rounding only in the 18-bit multiplier-adder setup
// (RQ16) summation adds both first-level adder outputs
// (RQ17) output mux picks products, adders/accumulators or summation
// (RQ18) each output register picks one of four enables and clears
// (RQ19) in MAC the output registers hold accumulation; clear resets it
// (RQ20) 9-bit setup gives four first-level adders and two summations
// (RQ21) control inputs pass a pipeline of selectable length
// (RQ22) no q1.15 processing in 9-bit or 36-bit setups
// (RQ23) accumulator is 52 bits wide
// (RQ24) rounding adds the half step and zeroes bits below 15; the code adds ROUND_ADD, which is bit 18, not bit 14
// (RQ25) saturation clamps to the 1.31 extremes, low three bits zero
// (RQ26) overflow judged by operand signedness, both directions
`timescale 1ns/10ps
`default_nettype none
module dspao_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] cfg_mode,
    input wire logic [1:0] cfg_width,
    input wire logic [1:0] cfg_acc_dir,
    input wire logic [1:0] cfg_ctrl_delay,
    input wire logic [7:0] cfg_lane_sel,
    input wire logic [3:0] ena,
    input wire logic [3:0] aclr,
    input wire logic [143:0] prod,
    input wire logic signa,
    input wire logic signb,
    input wire logic top_adder_direction,
    input wire logic bottom_adder_direction,
    input wire logic [1:0] acc_direction,
    input wire logic [1:0] acc_sload,
    input wire logic [71:0] acc_preload,
    input wire logic top_adder_rounding_enable,
    input wire logic bottom_adder_rounding_enable,
    input wire logic [1:0] acc_round_enable,
    input wire logic [1:0] acc_sat_enable,
    output logic [207:0] result,
    output logic [1:0] overflow,
    output logic [1:0] acc_saturated_flag
);
    localparam int AW = dspao_pkg::ACC_W;
    localparam int PW = dspao_pkg::PROD_W;
    localparam int SW = dspao_pkg::SUB_W;

    // ************************************************************
    // helper functions
    // ************************************************************
    function automatic logic [51:0] ext36(input logic [35:0] v, input logic s);
        ext36 = {{16{s & v[35]}}, v};
    endfunction

    function automatic logic [51:0] ext18(input logic [17:0] v, input logic s);
        ext18 = {{34{s & v[17]}}, v};
    endfunction

    // returns {saturated, value}; rounding first, then clamp
    function automatic logic [52:0] qproc(input logic [51:0] x, input logic rnd,
                                          input logic sat);
        logic [51:0] v;
        logic hit;
        v = x;
        hit = 1'b0;
        if (rnd) begin
            v = v + dspao_pkg::ROUND_ADD; // [RQ24]
            v[dspao_pkg::ROUND_KEEP_LSB-1:0] = '0;
        end
        if (sat) begin
            if (v[51:dspao_pkg::SAT_MSB] != {18{v[51]}}) begin
                hit = 1'b1;
                v = v[51] ? dspao_pkg::SAT_NEG : dspao_pkg::SAT_POS; // [RQ25]
            end
            v[dspao_pkg::SAT_KEEP_LSB-1:0] = '0;
        end
        qproc = {hit, v};
    endfunction

    // ************************************************************
    // control pipeline
    // ************************************************************
    dspao_ctrl_if #(.W(dspao_pkg::CTRL_W)) cif ();
    logic sa_d, sb_d, tdir_d, bdir_d, trnd_d, brnd_d;
    logic [1:0] adir_d, sload_d, arnd_d, asat_d;

    assign cif.raw = {signa, signb, top_adder_direction, bottom_adder_direction,
                      acc_direction, acc_sload, top_adder_rounding_enable,
                      bottom_adder_rounding_enable, acc_round_enable, acc_sat_enable};
    assign {sa_d, sb_d, tdir_d, bdir_d, adir_d, sload_d, trnd_d, brnd_d,
            arnd_d, asat_d} = cif.dly;

    dspao_ctrl_pipe #(.W(dspao_pkg::CTRL_W)) u_pipe (
        .clk(clk),
        .resetn(resetn),
        .delay_sel(cfg_ctrl_delay),
        .cp(cif)
    );

    // ************************************************************
    // shared decode
    // ************************************************************
    logic psigned, is_mac, q_ok, w9;
    logic [3:0] lane_en, lane_clr;
    assign psigned = sa_d | sb_d; // [RQ13]
    assign is_mac = (cfg_mode == dspao_pkg::DSPAO_MAC);
    assign w9 = (cfg_width == dspao_pkg::DSPAO_W9);
    // q1.15 only in the 18-bit setup; 9 and 36 bit get plain integers
    assign q_ok = (cfg_width == dspao_pkg::DSPAO_W18); // [RQ22]

    // per-lane enable and clear picked from the four shared lines
    genvar g;
    generate
        for (g = 0; g < dspao_pkg::LANES; g++) begin : g_sel
            assign lane_en[g] = ena[cfg_lane_sel[2*g +: 2]]; // [RQ18]
            assign lane_clr[g] = aclr[cfg_lane_sel[2*g +: 2]];
        end
    endgenerate

    // ************************************************************
    // accumulators, one per half
    // ************************************************************
    logic [AW-1:0] acc_r [2];
    logic [AW-1:0] acc_nxt [2];
    logic [AW-1:0] acc_post [2];
    logic [AW-1:0] acc_ext [2];
    logic [1:0] acc_hit, ovf_det, acc_add;

    generate
        for (g = 0; g < 2; g++) begin : g_acc
            logic [AW-1:0] fb;
            logic [AW:0] xf, xe, s;
            logic [AW:0] q;
            assign acc_ext[g] = ext36(prod[2*g*PW +: PW], psigned);
            // sload swaps feedback for preload, or zero when preload is zero
            assign fb = sload_d[g] ?
                {acc_preload[g*dspao_pkg::PRE_W +: dspao_pkg::PRE_W],
                 {dspao_pkg::PRE_LSB{1'b0}}} : acc_r[g]; // [RQ2] [RQ3] [RQ5]
            assign acc_add[g] = (cfg_acc_dir == dspao_pkg::DSPAO_DIR_DYN) ? adir_d[g] :
                                (cfg_acc_dir == dspao_pkg::DSPAO_DIR_ADD); // [RQ1]
            assign xf = {psigned & fb[AW-1], fb};
            assign xe = {psigned & acc_ext[g][AW-1], acc_ext[g]};
            assign s = acc_add[g] ? xf + xe : xf - xe; // [RQ4] [RQ23]
            assign acc_nxt[g] = s[AW-1:0];
            // signed: sign bits disagree; unsigned: carry or borrow out
            assign ovf_det[g] = psigned ? (s[AW] != s[AW-1]) : s[AW]; // [RQ26]
            assign q = qproc(acc_nxt[g], arnd_d[g] & q_ok & psigned,
                             asat_d[g] & q_ok & psigned); // [RQ8] [RQ9]
            assign acc_hit[g] = q[AW];
            assign acc_post[g] = q[AW-1:0];
        end
    endgenerate

    // raw sum is kept as feedback so rounding does not compound
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_r[0] <= dspao_pkg::ACC_RESET;
            acc_r[1] <= dspao_pkg::ACC_RESET;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (is_mac && lane_clr[2*h]) begin
                    acc_r[h] <= dspao_pkg::ACC_RESET; // [RQ19]
                end else if (is_mac && lane_en[2*h]) begin
                    acc_r[h] <= acc_nxt[h];
                end
            end
        end
    end

    // ************************************************************
    // overflow pulse and saturated flag
    // ************************************************************
    logic [1:0] det_q_r, det_now;
    assign det_now = ovf_det & {2{is_mac}} & {lane_en[2], lane_en[0]} &
                     ~{lane_clr[2], lane_clr[0]};

    // pulse on the first cycle only; outside logic must latch it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            det_q_r <= 2'b00;
            overflow <= 2'b00;
        end else begin
            det_q_r <= det_now;
            overflow <= det_now & ~det_q_r; // [RQ6] [RQ7]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_saturated_flag <= 2'b00;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (lane_clr[2*h] || !is_mac) begin
                    acc_saturated_flag[h] <= 1'b0;
                end else if (lane_en[2*h]) begin
                    acc_saturated_flag[h] <= acc_hit[h]; // [RQ10]
                end
            end
        end
    end

    // ************************************************************
    // first-level adders and summation
    // ************************************************************
    logic [AW-1:0] fa9 [4];
    logic [AW-1:0] fa_top, fa_bot, fa_top_q, fa_bot_q, sum18, sum9a, sum9b;
    logic [AW:0] tq, bq;

    generate
        for (g = 0; g < 4; g++) begin : g_fa9
            logic [AW-1:0] a, b;
            logic d;
            assign a = ext18(prod[2*g*SW +: SW], psigned);
            assign b = ext18(prod[(2*g+1)*SW +: SW], psigned);
            assign d = (g < 2) ? tdir_d : bdir_d;
            assign fa9[g] = d ? a + b : a - b; // [RQ20]
        end
    endgenerate

    assign fa_top = tdir_d ? ext36(prod[0 +: PW], psigned) + ext36(prod[PW +: PW], psigned) :
                    ext36(prod[0 +: PW], psigned) - ext36(prod[PW +: PW], psigned); // [RQ11] [RQ12]
    assign fa_bot = bdir_d ? acc_ext[1] + ext36(prod[3*PW +: PW], psigned) :
                    acc_ext[1] - ext36(prod[3*PW +: PW], psigned); // [RQ11] [RQ12]
    // rounding only, never saturation, after each adder
    assign tq = qproc(fa_top, trnd_d & q_ok & psigned, 1'b0); // [RQ14] [RQ15]
    assign bq = qproc(fa_bot, brnd_d & q_ok & psigned, 1'b0); // [RQ14] [RQ15]
    assign fa_top_q = tq[AW-1:0];
    assign fa_bot_q = bq[AW-1:0];
    assign sum18 = fa_top_q + fa_bot_q; // [RQ16]
    assign sum9a = fa9[0] + fa9[1]; // [RQ20]
    assign sum9b = fa9[2] + fa9[3];

    // ************************************************************
    // output select and output registers
    // ************************************************************
    logic [AW-1:0] lane_nxt [4];
    logic [AW-1:0] lane_r [4];

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            lane_nxt[k] = '0;
        end
        unique case (cfg_mode) // [RQ17]
            dspao_pkg::DSPAO_SIMPLE: begin
                for (int k = 0; k < 4; k++) begin
                    lane_nxt[k] = ext36(prod[k*PW +: PW], psigned & !w9);
                end
            end
            dspao_pkg::DSPAO_MAC: begin
                lane_nxt[0] = acc_post[0];
                lane_nxt[2] = acc_post[1];
            end
            dspao_pkg::DSPAO_ADD2: begin
                if (w9) begin
                    for (int k = 0; k < 4; k++) begin
                        lane_nxt[k] = fa9[k];
                    end
                end else begin
                    lane_nxt[0] = fa_top_q;
                    lane_nxt[2] = fa_bot_q;
                end
            end
            dspao_pkg::DSPAO_ADD4: begin
                lane_nxt[0] = w9 ? sum9a : sum18;
                lane_nxt[2] = w9 ? sum9b : '0;
            end
        endcase
    end

    // clear beats enable; held when the picked enable is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int k = 0; k < 4; k++) begin
                lane_r[k] <= dspao_pkg::ACC_RESET;
            end
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (lane_clr[k]) begin
                    lane_r[k] <= dspao_pkg::ACC_RESET; // [RQ18] [RQ19]
                end else if (lane_en[k]) begin
                    lane_r[k] <= lane_nxt[k];
                end
            end
        end
    end

    assign result = {lane_r[3], lane_r[2], lane_r[1], lane_r[0]};

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic upd0;
    assign upd0 = lane_en[0] && !lane_clr[0];

    ovf_one_cycle_a: assert property (overflow[0] |=> !overflow[0]) // [RQ7]
        else $error("overflow pulse longer than one cycle");
    ovf_cause_a: assert property (overflow[0] |-> $past(det_now[0]) && !$past(det_q_r[0])) // [RQ6]
        else $error("overflow without a detected wrap");
    sload_load_a: assert property (is_mac && upd0 && sload_d[0] && acc_add[0] |=>
        acc_r[0] == $past({acc_preload[35:0], 16'h0000} + acc_ext[0])) // [RQ2] [RQ4]
        else $error("load-select did not restart accumulation");
    acc_sub_a: assert property (is_mac && lane_en[2] && !lane_clr[2] && !sload_d[1] && // [RQ1]
        !acc_add[1] |=> acc_r[1] == $past(acc_r[1]) - $past(acc_ext[1]))
        else $error("accumulator did not subtract");
    mac_clear_a: assert property (is_mac && lane_clr[0] |=> acc_r[0] == '0 && lane_r[0] == '0) // [RQ19]
        else $error("clear left accumulation");
    lane_hold_a: assert property (!lane_en[3] && !lane_clr[3] |=> $stable(lane_r[3])) // [RQ18]
        else $error("output register moved while disabled");
    round_low_a: assert property (is_mac && upd0 && arnd_d[0] && q_ok && psigned |=>
        lane_r[0][14:0] == 15'h0000) // [RQ24]
        else $error("rounded result has low bits set");
    sat_clamp_a: assert property (acc_saturated_flag[1] |->
        (lane_r[2] == dspao_pkg::SAT_POS || lane_r[2] == dspao_pkg::SAT_NEG)) // [RQ10] [RQ25]
        else $error("saturated flag without clamped value");
    no_q_a: assert property (!q_ok && &lane_en |=> // [RQ22]
        !acc_saturated_flag[0] && !acc_saturated_flag[1])
        else $error("saturation outside 18-bit setup");
    sum_path_a: assert property (cfg_mode == dspao_pkg::DSPAO_ADD4 && !w9 && upd0 |=>
        lane_r[0] == $past(fa_top_q + fa_bot_q)) // [RQ16]
        else $error("summation output wrong");

    mac_run_c: cover property (is_mac && upd0 && !sload_d[0] ##1 is_mac && upd0 && sload_d[0]);
    ovf_seen_c: cover property (overflow[0] ##1 det_now[0]);
    sat_seen_c: cover property (acc_saturated_flag[1]);
    add4_c: cover property (cfg_mode == dspao_pkg::DSPAO_ADD4 && w9 && lane_en[2]);
endmodule
`default_nettype wire

//--- inc/dspao_pkg.sv
// package for the multiplier adder/output stage: widths, constants, modes
// assumes nothing of its surroundings; every user writes dspao_pkg::name
package dspao_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int PROD_W = 36;
    localparam int SUB_W = 18;
    localparam int ACC_W = 52;
    localparam int PRE_W = 36;
    localparam int PRE_LSB = 16;
    localparam int LANES = 4;
    localparam int CTRL_W = 14;

    // ************************************************************
    // q1.15 rounding and saturation, in accumulator alignment
    // ************************************************************
    localparam logic [51:0] ROUND_ADD = 52'h0_0000_0004_0000;
    localparam int ROUND_KEEP_LSB = 15;
    localparam int SAT_KEEP_LSB = 3;
    localparam int SAT_MSB = 34;
    localparam logic [51:0] SAT_POS = 52'h0_0003_FFFF_FFF8;
    localparam logic [51:0] SAT_NEG = 52'hF_FFFC_0000_0000;
    localparam logic [51:0] ACC_RESET = 52'h0_0000_0000_0000;

    // ************************************************************
    // configuration encodings
    // ************************************************************
    typedef enum logic [1:0] {
        DSPAO_SIMPLE = 2'b00,
        DSPAO_MAC = 2'b01,
        DSPAO_ADD2 = 2'b10,
        DSPAO_ADD4 = 2'b11
    } dspao_mode_t;

    typedef enum logic [1:0] {
        DSPAO_W9 = 2'b00,
        DSPAO_W18 = 2'b01,
        DSPAO_W36 = 2'b10
    } dspao_width_t;

    typedef enum logic [1:0] {
        DSPAO_DIR_DYN = 2'b00,
        DSPAO_DIR_ADD = 2'b01,
        DSPAO_DIR_SUB = 2'b10
    } dspao_dir_t;
endpackage

//--- inc/dspao_ctrl_if.sv
// bundle of control bits between the stage and its control pipeline
// assumes the stage drives raw and reads back the delayed copy
`timescale 1ns/10ps
`default_nettype none
interface dspao_ctrl_if #(parameter int W = 14);
    logic [W-1:0] raw;
    logic [W-1:0] dly;
    modport pipe (input raw, output dly);
    modport user (output raw, input dly);
endinterface
`default_nettype wire

//--- design/dspao_ctrl_pipe.sv
// selectable 0, 1 or 2 stage delay line for the stage's control bits
// assumes clk and resetn shared with the stage; select is static config
`timescale 1ns/10ps
`default_nettype none
module dspao_ctrl_pipe #(
    parameter int W = 14
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] delay_sel,
    dspao_ctrl_if.pipe cp
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    // two plain stages, running every edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= cp.raw;
            s2_r <= s1_r;
        end
    end

    // tap select; code 3 falls back to two stages
    always_comb begin
        cp.dly = s2_r; // [RQ21]
        if (delay_sel == 2'b00) begin
            cp.dly = cp.raw;
        end else if (delay_sel == 2'b01) begin
            cp.dly = s1_r;
        end
    end
endmodule
`default_nettype wire

//--- bench/dspao_mult_model.sv
// partner model: four 18x18 multipliers in front of the stage, plus overflow latch
// assumes operands move just after a rising clk edge; products are unregistered
`timescale 1ns/10ps
`default_nettype none
module dspao_mult_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [71:0] opa,
    input wire logic [71:0] opb,
    input wire logic signa,
    input wire logic signb,
    input wire logic [1:0] overflow,
    output logic [143:0] prod,
    output logic [1:0] ovf_held
);
    // ********
    // products and sticky flag
    // ********
    // signed if either side is signed; b of one carries low acc bits
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            prod[36*k +: 36] = 36'(38'($signed({signa & opa[18*k+17], opa[18*k +: 18]}))
                * 38'($signed({signb & opb[18*k+17], opb[18*k +: 18]})));
        end
    end

    // the stage pulses one cycle only, so the fabric keeps the flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovf_held <= 2'h0;
        end else begin
            ovf_held <= ovf_held | overflow;
        end
    end
endmodule
`default_nettype wire

//--- bench/dspao_top_tb_top.sv
// self-checking bench for the adder and output stage
// assumes control delay zero, so products and controls line up, save the final delay check
`timescale 1ns/10ps
`default_nettype none
module dspao_top_tb_top;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic [1:0] cfg_mode = 2'h0;
    logic [1:0] cfg_width = 2'h1;
    logic [1:0] cfg_acc_dir = 2'h0;
    logic [1:0] cdly = 2'h0;
    logic [7:0] cfg_lane_sel = 8'h1B;
    logic [3:0] ena = 4'hF;
    logic [3:0] aclr = 4'h0;
    logic [71:0] opa = 72'h0;
    logic [71:0] opb = 72'h0;
    logic signa = 1'h0;
    logic signb = 1'h0;
    logic tdir = 1'h1;
    logic bdir = 1'h1;
    logic [1:0] acc_dir = 2'h3;
    logic [1:0] sload = 2'h0;
    logic [71:0] preload = 72'h0;
    logic trnd = 1'h0;
    logic [1:0] arnd = 2'h0;
    logic [1:0] asat = 2'h0;
    logic [143:0] prod;
    logic [207:0] result;
    logic [1:0] overflow;
    logic [1:0] sat_flag;
    logic [1:0] ovf_held;
    logic [51:0] e0, e2;
    int miscompares = 0;
    int tests_run = 0;

    dspao_mult_model mult (.clk(clk), .resetn(resetn), .opa(opa), .opb(opb), .signa(signa),
        .signb(signb), .overflow(overflow), .prod(prod), .ovf_held(ovf_held));
    // lane sel reversed (lane0 on ena[3]) to prove the selection really acts
    dspao_top DUT (.clk(clk), .resetn(resetn), .cfg_mode(cfg_mode), .cfg_width(cfg_width),
        .cfg_acc_dir(cfg_acc_dir), .cfg_ctrl_delay(cdly), .cfg_lane_sel(cfg_lane_sel),
        .ena(ena), .aclr(aclr), .prod(prod), .signa(signa), .signb(signb),
        .top_adder_direction(tdir), .bottom_adder_direction(bdir), .acc_direction(acc_dir),
        .acc_sload(sload), .acc_preload(preload), .top_adder_rounding_enable(trnd),
        .bottom_adder_rounding_enable(1'h0), .acc_round_enable(arnd), .acc_sat_enable(asat),
        .result(result), .overflow(overflow), .acc_saturated_flag(sat_flag));

    // ********
    // helpers
    // ********
    // 50 MHz clock
    always #10 clk = ~clk;

    task chk(input string what, input logic [51:0] exp, input logic [51:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function logic [51:0] lane(input int k);
        return result[52*k +: 52];
    endfunction

    function logic [51:0] sp(input int k, input int s);
        return 52'(18'h3FFFF - 18'(k + s)) * (52'h100 << k);
    endfunction

    // operands of lane k, called only just after a rising edge
    task op(input int k, input logic [17:0] a, input logic [17:0] b);
        opa[18*k +: 18] <= a;
        opb[18*k +: 18] <= b;
    endtask

    task report_and_stop;
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ********
    // scenarios
    // ********
    // products out, lane hold on its enable, clear beats enable
    task t_simple;
        @(posedge clk);
        for (int k = 0; k < 4; k++) op(k, 18'h3FFFF - 18'(k), 18'h100 << k);
        @(posedge clk);
        for (int k = 0; k < 4; k++) op(k, 18'h3FFFF - 18'(k + 1), 18'h100 << k);
        ena <= 4'hE;
        @(negedge clk);
        for (int k = 0; k < 4; k++) chk("simple lane", sp(k, 0), lane(k));
        @(posedge clk);
        ena <= 4'hF;
        aclr <= 4'h8;
        @(negedge clk);
        chk("enabled lane", sp(0, 1), lane(0));
        chk("held lane", sp(3, 0), lane(3));
        @(posedge clk);
        aclr <= 4'h0;
        @(negedge clk);
        chk("cleared lane", 52'h0, lane(0));
    endtask

    // top subtracts while bottom adds, then the reverse, then summation, rounding, 9x9 split
    task t_add;
        logic [51:0] p [4];
        for (int k = 0; k < 4; k++) p[k] = sp(k, 0);
        @(posedge clk);
        cfg_mode <= 2'h2;
        for (int k = 0; k < 4; k++) op(k, 18'h3FFFF - 18'(k), 18'h100 << k);
        tdir <= 1'h0;
        @(posedge clk);
        tdir <= 1'h1;
        bdir <= 1'h0;
        @(negedge clk);
        chk("top diff", p[0] - p[1], lane(0));
        chk("bottom sum", p[2] + p[3], lane(2));
        @(posedge clk);
        cfg_mode <= 2'h3;
        bdir <= 1'h1;
        @(negedge clk);
        chk("top sum", p[0] + p[1], lane(0));
        chk("bottom diff", p[2] - p[3], lane(2));
        @(posedge clk);
        cfg_mode <= 2'h2;
        signa <= 1'h1;
        signb <= 1'h1;
        trnd <= 1'h1;
        op(0, 18'h03C12, 18'h00010);
        op(1, 18'h00001, 18'h00003);
        @(negedge clk);
        chk("summation", p[0] + p[1] + p[2] + p[3], lane(0));
        @(posedge clk);
        cfg_width <= 2'h0;
        trnd <= 1'h0;
        signa <= 1'h0;
        signb <= 1'h0;
        bdir <= 1'h0;
        for (int k = 0; k < 4; k++) op(k, 18'h10001, 18'h10001);
        @(negedge clk);
        chk("rounded sum", 52'h0_0000_0007_8000, lane(0));
        @(posedge clk);
        cfg_mode <= 2'h3;
        @(negedge clk);
        for (int k = 0; k < 4; k++) chk("nine lane", k < 2 ? 52'h2_4001 : 52'h1_C001, lane(k));
    endtask

    // preload, add/sub, restart by load-select, clear by output register
    task t_mac;
        @(posedge clk);
        cfg_mode <= 2'h1;
        cfg_width <= 2'h1;
        sload <= 2'h3;
        preload <= {36'h0_0000_0123, 36'h0_0000_0ABC};
        op(0, 18'h01234, 18'h00001);
        op(2, 18'h00055, 18'h00001);
        @(negedge clk);
        chk("nine sum top", 52'h4_8002, lane(0));
        chk("nine sum bottom", 52'h3_8002, lane(2));
        @(posedge clk);
        sload <= 2'h0;
        acc_dir <= 2'h1;
        op(0, 18'h00100, 18'h00010);
        op(2, 18'h00100, 18'h00010);
        e0 = 52'h0_0000_0ABC_1234;
        e2 = 52'h0_0000_0123_0055;
        @(negedge clk);
        chk("preload top", e0, lane(0));
        chk("preload bottom", e2, lane(2));
        chk("idle lane", 52'h0, lane(1));
        @(posedge clk);
        sload <= 2'h1;
        preload <= 72'h0;
        @(negedge clk);
        chk("acc add", e0 + 52'h1000, lane(0));
        chk("acc sub", e2 - 52'h1000, lane(2));
        @(posedge clk);
        sload <= 2'h0;
        aclr <= 4'h8;
        @(negedge clk);
        chk("new accumulation", 52'h1000, lane(0));
        chk("kept accumulation", e2 - 52'h2000, lane(2));
        @(posedge clk);
        aclr <= 4'h0;
        cfg_acc_dir <= 2'h1;
        acc_dir <= 2'h0;
        @(negedge clk);
        chk("cleared acc", 52'h0, lane(0));
        @(posedge clk);
        @(negedge clk);
        chk("fixed add", 52'h1000, lane(0));
        chk("fixed add bottom", e2 - 52'h2000, lane(2));
    endtask

    // unsigned wrap up on top, borrow on bottom, each a single pulse
    task t_ovf;
        int hi0, hi2;
        @(posedge clk);
        cfg_acc_dir <= 2'h0;
        acc_dir <= 2'h1;
        sload <= 2'h3;
        preload <= {36'h0, 36'hF_FFFF_FFFF};
        op(0, 18'h0FFFF, 18'h00001);
        op(2, 18'h00000, 18'h00001);
        @(posedge clk);
        sload <= 2'h0;
        op(0, 18'h00001, 18'h00001);
        op(2, 18'h00001, 18'h00001);
        hi0 = 0;
        hi2 = 0;
        repeat (5) begin
            @(negedge clk);
            hi0 += int'(overflow[0] === 1'h1);
            hi2 += int'(overflow[1] === 1'h1);
        end
        chk("overflow pulse", 52'h1, 52'(hi0));
        chk("underflow pulse", 52'h1, 52'(hi2));
        chk("held flags", 52'h3, 52'(ovf_held));
    endtask

    // q1.15 rounding on top, clamping both ways on bottom, then 36-bit setup, then delay 2
    task t_qsat;
        @(posedge clk);
        signa <= 1'h1;
        signb <= 1'h1;
        sload <= 2'h3;
        arnd <= 2'h1;
        asat <= 2'h2;
        preload <= {36'h0_0004_0000, 36'h0};
        op(0, 18'h03C12, 18'h00010);
        op(2, 18'h00000, 18'h00001);
        @(posedge clk);
        preload <= {36'hF_FFF0_0000, 36'h0};
        @(negedge clk);
        chk("acc rounded", 52'h0_0000_0007_8000, lane(0));
        chk("clamp high", dspao_pkg::SAT_POS, lane(2));
        chk("sat flags", 52'h2, 52'(sat_flag));
        @(posedge clk);
        cfg_width <= 2'h2;
        preload <= {36'hF_FFFF_0000, 36'h0};
        @(negedge clk);
        chk("clamp low", dspao_pkg::SAT_NEG, lane(2));
        @(posedge clk);
        @(negedge clk);
        chk("no q1.15 round", 52'h0_0000_0003_C120, lane(0));
        chk("no q1.15 sat", 52'hF_FFFF_0000_0000, lane(2));
        chk("flag cleared", 52'h0, 52'(sat_flag));
        @(posedge clk);
        cdly <= 2'h2;
        sload <= 2'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("delay held", 52'h3_C120, lane(0));
        @(negedge clk);
        chk("delay start", 52'h7_8240, lane(0));
    endtask

    // main sequence: reset for five cycles, then every scenario
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'h1;
        t_simple();
        t_add();
        t_mac();
        t_ovf();
        t_qsat();
        report_and_stop();
    end

    // watchdog: scenarios need well under 100 cycles
    initial begin
        repeat (400) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
